//--- inc/rop_pkg.sv
// Purpose: Shared constants and types for the return and option instruction group.
// Assumes: 14-bit instruction words, 8-bit data, 13-bit program counter.
// Notes: Four phases make one instruction cycle.
`default_nettype none
package rop_pkg;
    localparam int INSN_W = 14;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam logic [13:0] ENC_NOP_MASK = 14'h3f9f;
    localparam logic [13:0] ENC_NOP = 14'h0000;
    localparam logic [13:0] ENC_RET_IRQ = 14'h0009;
    localparam logic [13:0] ENC_LOAD_OPT = 14'h0062;
    localparam logic [13:0] ENC_RETURN = 14'h0008;
    localparam logic [13:0] ENC_RETLIT_MASK = 14'h3c00;
    localparam logic [13:0] ENC_RETLIT = 14'h3400;
    localparam int GIE_BIT = 7;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'hff;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;

    typedef enum logic [1:0] {
        ROP_Q1,
        ROP_Q2,
        ROP_Q3,
        ROP_Q4
    } rop_phase_t;

    typedef enum logic [2:0] {
        ROP_OP_OTHER,
        ROP_OP_NOP,
        ROP_OP_RET_IRQ,
        ROP_OP_LOAD_OPT,
        ROP_OP_RET_LIT,
        ROP_OP_RETURN
    } rop_op_t;

    typedef struct packed {
        logic pop;
        logic [12:0] pc;
    } rop_pc_load_t;
endpackage : rop_pkg
`default_nettype wire

//--- hw/rop_decode.sv
// Purpose: Classifies one instruction word into this block's operations.
// Assumes: Word is stable while decoded.
// Notes: Purely combinational.
`default_nettype none
module rop_decode (
    input wire logic [13:0] insn_in,
    output rop_pkg::rop_op_t op_out
);
    wire is_nop = (insn_in & rop_pkg::ENC_NOP_MASK) == rop_pkg::ENC_NOP;
    wire is_rirq = insn_in == rop_pkg::ENC_RET_IRQ;
    wire is_opt = insn_in == rop_pkg::ENC_LOAD_OPT;
    wire is_ret = insn_in == rop_pkg::ENC_RETURN;
    wire is_rlit = (insn_in & rop_pkg::ENC_RETLIT_MASK) == rop_pkg::ENC_RETLIT;
    assign op_out = is_rirq ? rop_pkg::ROP_OP_RET_IRQ :
                    is_ret ? rop_pkg::ROP_OP_RETURN :
                    is_opt ? rop_pkg::ROP_OP_LOAD_OPT :
                    is_rlit ? rop_pkg::ROP_OP_RET_LIT :
                    is_nop ? rop_pkg::ROP_OP_NOP : rop_pkg::ROP_OP_OTHER;
endmodule : rop_decode
`default_nettype wire

//--- hw/rop_core.sv
// Purpose: Executes no-op, interrupt return, option load, literal return and return.
// Assumes: Instruction and stack top are held steady through the cycle they belong to.
// Notes: Flush cycle after each return spends a whole idle instruction cycle.
//
// Behaviour
// [RULE1] A no-op decodes in Q1 and changes nothing in Q2 to Q4 of its one cycle.
// [RULE2] Interrupt return loads the counter from the stack top, sets the enable, takes two cycles.
// [RULE3] The enable is a bit of the interrupt control register, set in Q3, stack popped in Q4.
// [RULE4] Option load copies the accumulator into the option register in one cycle, no flags.
// [RULE5] Literal return puts the literal in the accumulator and pops the stack over two cycles.
// [RULE6] Plain return pops in Q4 of the first cycle, idles one cycle, keeps flags and enable.
`default_nettype none
module rop_core #(
    parameter int INSN_W = rop_pkg::INSN_W,
    parameter int DATA_W = rop_pkg::DATA_W,
    parameter int PC_W = rop_pkg::PC_W
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [INSN_W-1:0] insn_in,
    input wire logic [PC_W-1:0] stack_top_in,
    output logic [PC_W-1:0] pc_out,
    output logic stack_pop_out,
    output logic [DATA_W-1:0] acc_out,
    output logic [DATA_W-1:0] option_out,
    output logic [DATA_W-1:0] irq_control_reg_out,
    output logic global_irq_enable_out,
    output logic idle_cycle_out,
    output logic [1:0] phase_out
);
    rop_pkg::rop_phase_t phase;
    rop_pkg::rop_phase_t next_phase;
    rop_pkg::rop_op_t op;
    rop_pkg::rop_op_t op_q;
    logic idle;
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] option_reg;
    logic [DATA_W-1:0] irq_control_reg;
    logic [DATA_W-1:0] insn_q_lit;
    logic pop;
    rop_pkg::rop_op_t next_op_q;
    logic next_idle;

    // The opcode patterns, the literal field and the stack carrier are fixed in the package.
    if (INSN_W != rop_pkg::INSN_W) begin : g_bad_insn_w
        $error("rop_core: instruction width must match the opcode patterns");
    end
    if (DATA_W != rop_pkg::DATA_W) begin : g_bad_data_w
        $error("rop_core: data width must match the literal field");
    end
    if (PC_W != rop_pkg::PC_W) begin : g_bad_pc_w
        $error("rop_core: counter width must match the stack carrier");
    end
    if (rop_pkg::GIE_BIT >= DATA_W) begin : g_bad_gie_bit
        $error("rop_core: enable bit lies outside the control register");
    end

    rop_decode u_dec (
        .insn_in(insn_in),
        .op_out(op)
    );

    // Phase decode; the enable is set one phase ahead of the pop.
    wire at_q1 = phase == rop_pkg::ROP_Q1;
    wire at_q3 = phase == rop_pkg::ROP_Q3;
    wire at_q4 = phase == rop_pkg::ROP_Q4;
    wire live = !idle;
    wire q_ret_irq = op_q == rop_pkg::ROP_OP_RET_IRQ;
    wire q_return = op_q == rop_pkg::ROP_OP_RETURN;
    wire q_ret_lit = op_q == rop_pkg::ROP_OP_RET_LIT;
    wire q_load_opt = op_q == rop_pkg::ROP_OP_LOAD_OPT;
    wire is_branch = q_ret_irq || q_return || q_ret_lit;
    wire set_gie = live && at_q3 && q_ret_irq; // [RULE3]
    wire do_pop = live && at_q4 && is_branch; // [RULE2] [RULE5] [RULE6]
    wire do_opt = live && at_q4 && q_load_opt; // [RULE4]
    wire do_lit = live && at_q4 && q_ret_lit; // [RULE5]

    // Carries the pop strobe and the popped address together to the counter register.
    rop_pkg::rop_pc_load_t pc_load;
    assign pc_load = '{pop: do_pop, pc: stack_top_in};

    always_comb begin
        case (phase)
            rop_pkg::ROP_Q1: next_phase = rop_pkg::ROP_Q2;
            rop_pkg::ROP_Q2: next_phase = rop_pkg::ROP_Q3;
            rop_pkg::ROP_Q3: next_phase = rop_pkg::ROP_Q4;
            rop_pkg::ROP_Q4: next_phase = rop_pkg::ROP_Q1;
            default: next_phase = rop_pkg::ROP_Q1;
        endcase
    end

    // A word presented in the idle cycle after a return is dropped and runs as a no-op.
    always_comb begin
        next_op_q = op_q;
        next_idle = idle;
        if (at_q1) begin
            next_op_q = idle ? rop_pkg::ROP_OP_NOP : op; // [RULE1]
        end
        if (at_q4) begin
            next_idle = live && is_branch; // [RULE2] [RULE5] [RULE6]
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase <= rop_pkg::ROP_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op_q <= rop_pkg::ROP_OP_NOP;
            idle <= 1'b0;
        end else begin
            op_q <= next_op_q;
            idle <= next_idle;
        end
    end

    // The stack top is taken at the Q4 edge, so it must already be settled by then.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc <= rop_pkg::PC_RESET;
            pop <= 1'b0;
        end else begin
            pop <= pc_load.pop;
            if (pc_load.pop) begin
                pc <= pc_load.pc; // [RULE2] [RULE5] [RULE6]
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            insn_q_lit <= 8'h00;
        end else if (at_q1) begin
            insn_q_lit <= insn_in[DATA_W-1:0]; // [RULE5]
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc <= rop_pkg::ACC_RESET;
        end else if (do_lit) begin
            acc <= insn_q_lit; // [RULE5]
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            option_reg <= rop_pkg::OPTION_RESET;
        end else if (do_opt) begin
            option_reg <= acc; // [RULE4]
        end
    end

    // One flop per control bit; only the enable bit has a setter in this group.
    for (genvar b = 0; b < DATA_W; b++) begin : g_ctrl_bit
        wire set_bit = set_gie && (b == rop_pkg::GIE_BIT);
        always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                irq_control_reg[b] <= rop_pkg::IRQ_CTRL_RESET[b];
            end else if (set_bit) begin
                irq_control_reg[b] <= 1'b1; // [RULE2] [RULE3]
            end
        end
    end

    // Every port leaves from a flop, so all outputs trail the state by one clock.
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pc_out <= rop_pkg::PC_RESET;
            stack_pop_out <= 1'b0;
        end else begin
            pc_out <= pc;
            stack_pop_out <= pop;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            acc_out <= rop_pkg::ACC_RESET;
        end else begin
            acc_out <= acc;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            option_out <= rop_pkg::OPTION_RESET;
        end else begin
            option_out <= option_reg;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_control_reg_out <= rop_pkg::IRQ_CTRL_RESET;
            global_irq_enable_out <= 1'b0;
        end else begin
            irq_control_reg_out <= irq_control_reg;
            global_irq_enable_out <= irq_control_reg[rop_pkg::GIE_BIT];
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_cycle_out <= 1'b0;
            phase_out <= 2'h0;
        end else begin
            idle_cycle_out <= idle;
            phase_out <= phase;
        end
    end
endmodule : rop_core
`default_nettype wire

//--- bench/rop_chk_sva.sv
// Purpose: Port assertions for the return and option group.
// Assumes: One clock, reset active low.
// Notes: Bound to rop_core below.
`default_nettype none
module rop_chk (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [12:0] pc_out,
    input wire logic stack_pop_out,
    input wire logic [7:0] acc_out,
    input wire logic [7:0] option_out,
    input wire logic [7:0] irq_control_reg_out,
    input wire logic global_irq_enable_out,
    input wire logic idle_cycle_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    pop_gap_a: assert property (stack_pop_out |=> !stack_pop_out [*7])
        else $error("pop pulse too long or too close");
    idle_len_a: assert property ($rose(idle_cycle_out) |-> idle_cycle_out [*4] ##1 !idle_cycle_out)
        else $error("idle cycle not four clocks");
    gie_copy_a: assert property (global_irq_enable_out == irq_control_reg_out[rop_pkg::GIE_BIT])
        else $error("enable differs from control bit");
    gie_pop_a: assert property ($rose(global_irq_enable_out) |-> ##1 stack_pop_out)
        else $error("enable not set one phase before pop");
    opt_src_a: assert property ($changed(option_out) |-> option_out == $past(acc_out))
        else $error("option not taken from accumulator");
    pc_pop_a: assert property ($changed(pc_out) |-> stack_pop_out || $past(stack_pop_out))
        else $error("counter moved without pop");
    acc_pop_a: assert property ($changed(acc_out) |-> stack_pop_out || $past(stack_pop_out))
        else $error("accumulator moved without pop");
    cover property ($rose(global_irq_enable_out));
    cover property ($rose(idle_cycle_out));
    cover property ($changed(option_out));
endmodule : rop_chk
bind rop_core rop_chk chk_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .pc_out(pc_out),
    .stack_pop_out(stack_pop_out), .acc_out(acc_out), .option_out(option_out),
    .irq_control_reg_out(irq_control_reg_out), .idle_cycle_out(idle_cycle_out),
    .global_irq_enable_out(global_irq_enable_out));
`default_nettype wire

//--- bench/rop_tb.sv
// Purpose: Self-checking bench for the return and option group.
// Assumes: One instruction per four clocks.
// Notes: Inputs change at the falling edge.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [13:0] insn = 14'h0000;
    logic [12:0] top = 13'h0000;
    logic [12:0] pc;
    logic [7:0] acc, opt, irq;
    logic [1:0] ph;
    logic global_irq_enable, idle, popd;
    int errors = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    rop_core dut (.clock_in(clk), .rst_n_in(rst_n), .insn_in(insn), .stack_top_in(top),
        .pc_out(pc), .stack_pop_out(popd), .acc_out(acc), .option_out(opt), .phase_out(ph),
        .irq_control_reg_out(irq), .global_irq_enable_out(global_irq_enable), .idle_cycle_out(idle));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask : chk
    task automatic run(input logic [13:0] c, input logic [12:0] t, input logic i,
        input logic [13:0] nx);
        for (int k = 0; k < 8 && ph !== 2'h3; k++) @(negedge clk);
        insn = c;
        top = t;
        repeat (4) @(negedge clk);
        insn = nx;
        @(negedge clk);
        chk("idle", 16'(idle), 16'(i));
        chk("pop", 16'(popd), 16'(i));
        chk("phase", 16'(ph), 16'h0000);
    endtask : run
    task automatic t_retlit;
        run(rop_pkg::ENC_RETLIT | 14'h005a, 13'h0abc, 1'b1, rop_pkg::ENC_LOAD_OPT);
        chk("pc", 16'(pc), 16'h0abc);
        chk("acc", 16'(acc), 16'h005a);
        run(rop_pkg::ENC_NOP, 13'h0abc, 1'b0, rop_pkg::ENC_NOP);
        chk("option", 16'(opt), 16'h00ff);
    endtask : t_retlit
    task automatic t_opt;
        run(rop_pkg::ENC_LOAD_OPT, 13'h0abc, 1'b0, rop_pkg::ENC_NOP);
        chk("option", 16'(opt), 16'h005a);
        chk("pc", 16'(pc), 16'h0abc);
    endtask : t_opt
    task automatic t_retirq;
        run(rop_pkg::ENC_RET_IRQ, 13'h1234, 1'b1, rop_pkg::ENC_NOP);
        chk("pc", 16'(pc), 16'h1234);
        chk("irq", 16'(irq), 16'h0080);
    endtask : t_retirq
    task automatic t_ret;
        run(rop_pkg::ENC_RETURN, 13'h0777, 1'b1, rop_pkg::ENC_NOP);
        chk("pc", 16'(pc), 16'h0777);
        chk("gie", 16'(global_irq_enable), 16'h0001);
    endtask : t_ret
    task automatic t_nop;
        run(14'h0060, 13'h1fff, 1'b0, rop_pkg::ENC_NOP);
        chk("state", {pc[7:0], acc}, 16'h775a);
        chk("regs", {opt, irq}, 16'h5a80);
        run(14'h0700, 13'h1fff, 1'b0, rop_pkg::ENC_NOP);
        chk("pc", 16'(pc), 16'h0777);
        chk("regs", {opt, irq}, 16'h5a80);
    endtask : t_nop
    task automatic final_report;
        $display("errors %0d, comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        t_retlit();
        t_opt();
        t_retirq();
        t_ret();
        t_nop();
        final_report();
    end
    initial begin
        #50000;
        errors++;
        final_report();
    end
endmodule : tb_top
`default_nettype wire
